/* File: logic/input_channel_scan.sv */
// input channel scan: measures, filters and scales eight inputs
// assumes samples, levels and settings are synchronous to clk_sys_in
// Function
// - eight channels, each one selected type
// - disabled channel sends no messages
// - voltage offset volts, resolution volts per bit
// - current offset milliamps, resolution milliamps per bit
// - granularity one millivolt, one microamp
// - digital high level means on
// - digital state off zero, on one
// - digital channels skip limit checking
// - low maximum frequency times rising edge intervals
// - no edge for ten seconds reads zero
// - low range results in hundredths hertz
// - higher frequencies in whole hertz
// - duty cycle in hundredths of percent
// - non frequency inputs sampled every millisecond
// - filter none, moving or repeating average
`timescale 1ns/10ps
`default_nettype none
`include "uic_cfg.svh"
module input_channel_scan #(
	parameter int NCH = `NUM_CH,
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int SCAN_CYCLES = `SCAN_CYC,
	parameter int TIMEOUT_CYCLES = `EDGE_TIMEOUT_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire uic_pkg::chan_type_t chan_type_in [NCH],
	input wire uic_pkg::filt_sel_t filt_sel_in [NCH],
	input wire logic [31:0] sample_in [NCH],
	input wire logic [NCH-1:0] level_in,
	input wire logic [31:0] offset_in [NCH],
	input wire logic [31:0] resol_in [NCH],
	input wire logic [31:0] err_lo_in [NCH],
	input wire logic [31:0] err_hi_in [NCH],
	input wire logic [15:0] freq_max_in [NCH],
	input wire logic [15:0] window_ms_in [NCH],
	input wire logic msg_ready_in,
	output logic msg_valid_out,
	output logic [$clog2(NCH)+35:0] msg_data_out,
	output logic [NCH-1:0] err_out
);
	import uic_pkg::*;

	localparam int CW = $clog2(NCH);
	localparam int MW = CW + 36;
	localparam int PW = `PER_W;
	localparam int DW = `DIV_W;
	localparam logic [PW-1:0] TO = PW'(TIMEOUT_CYCLES);

	function automatic logic [31:0] sat32(input logic [DW-1:0] v);
		sat32 = (v[DW-1:32] != '0) ? 32'hFFFF_FFFF : v[31:0];
	endfunction

	logic [31:0] scan_cnt_q;
	logic tick_q;
	chan_type_t type_q [NCH];
	chan_type_t cur_type;
	logic [NCH-1:0] chg;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] low_mode;
	logic [NCH-1:0] take;
	logic [NCH-1:0] lvl_q;
	logic [NCH-1:0] seen_q;
	logic [NCH-1:0] fresh_q;
	logic [NCH-1:0] err_q;
	logic [PW-1:0] per_cnt_q [NCH];
	logic [PW-1:0] hi_cnt_q [NCH];
	logic [PW-1:0] per_q [NCH];
	logic [PW-1:0] hi_q [NCH];
	logic [15:0] win_q [NCH];
	logic [15:0] edges_q [NCH];
	logic [15:0] edges_lat_q [NCH];
	logic [31:0] hist_q [NCH][3];
	logic [33:0] rpt_acc_q [NCH];
	logic [1:0] rpt_n_q [NCH];
	logic [31:0] rpt_hold_q [NCH];
	logic [33:0] mov_sum;
	logic [33:0] rpt_sum;
	logic [31:0] filt_val;
	seq_state_t state_q;
	chan_type_t meas_type_q;
	logic [CW-1:0] ch_q;
	logic last_ch;
	logic hund;
	logic [31:0] meas_q;
	logic [MW-1:0] word_q;
	logic go_q;
	logic [DW-1:0] num_q;
	logic [31:0] den_q;
	logic [DW-1:0] quo_q;
	logic [31:0] rem_q;
	logic [5:0] dcnt_q;
	logic busy_q;
	logic div_done;
	logic [32:0] trial;

	word_stream_if #(.W(MW)) wr_if ();

	// one scan tick per millisecond paces every non-frequency sample
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			scan_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (scan_cnt_q == 32'(SCAN_CYCLES - 1)) begin
			scan_cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			scan_cnt_q <= scan_cnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			chg[c] = chan_type_in[c] != type_q[c];
			rise[c] = level_in[c] && !lvl_q[c];
			low_mode[c] = freq_max_in[c] <= `LOWF_LIMIT_HZ;
			take[c] = (state_q == SQ_MEAS) && (ch_q == CW'(c));
		end
	end

	assign cur_type = type_q[ch_q];
	assign last_ch = ch_q == CW'(NCH - 1);
	assign hund = (cur_type == CT_PWM) || (cur_type == CT_FREQ
		&& low_mode[ch_q]);

	always_ff @(posedge clk_sys_in) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_in) begin
				type_q[c] <= CT_OFF;
			end else begin
				type_q[c] <= chan_type_in[c];
			end
		end
	end

	// period and high time between rising edges, cleared to zero at timeout
	always_ff @(posedge clk_sys_in) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_in || chg[c]) begin
				lvl_q[c] <= 1'b0;
				seen_q[c] <= 1'b0;
				per_cnt_q[c] <= '0;
				hi_cnt_q[c] <= '0;
				per_q[c] <= '0;
				hi_q[c] <= '0;
			end else begin
				lvl_q[c] <= level_in[c];
				if (rise[c]) begin
					per_cnt_q[c] <= PW'(1);
					hi_cnt_q[c] <= PW'(1);
					seen_q[c] <= 1'b1;
					if (seen_q[c]) begin
						per_q[c] <= per_cnt_q[c];
						hi_q[c] <= hi_cnt_q[c];
					end
				end else if (per_cnt_q[c] == TO) begin
					per_q[c] <= '0;
					hi_q[c] <= '0;
					seen_q[c] <= 1'b0;
				end else begin
					per_cnt_q[c] <= per_cnt_q[c] + PW'(1);
					if (level_in[c]) begin
						hi_cnt_q[c] <= hi_cnt_q[c] + PW'(1);
					end
				end
			end
		end
	end

	// frequency results arrive on their own events, not on the scan;
	// a result waits until the next scan pass reaches its channel to be picked up
	always_ff @(posedge clk_sys_in) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_in || chg[c]) begin
				win_q[c] <= '0;
				edges_q[c] <= '0;
				edges_lat_q[c] <= '0;
				fresh_q[c] <= 1'b0;
			end else begin
				if (take[c]) begin
					fresh_q[c] <= 1'b0;
				end
				if (low_mode[c]) begin
					win_q[c] <= '0;
					edges_q[c] <= '0;
					if ((rise[c] || per_cnt_q[c] == TO) && seen_q[c]) begin
						fresh_q[c] <= 1'b1;
					end
				end else if (tick_q
					&& win_q[c] + 16'h0001 >= window_ms_in[c]) begin
					win_q[c] <= '0;
					edges_lat_q[c] <= edges_q[c] + 16'(rise[c]);
					edges_q[c] <= '0;
					fresh_q[c] <= 1'b1;
				end else begin
					if (tick_q) begin
						win_q[c] <= win_q[c] + 16'h0001;
					end
					if (rise[c]) begin
						edges_q[c] <= edges_q[c] + 16'h0001;
					end
				end
			end
		end
	end

	// four-sample averages; history starts from zero after a clear
	always_comb begin
		mov_sum = 34'(meas_q) + 34'(hist_q[ch_q][0])
			+ 34'(hist_q[ch_q][1]) + 34'(hist_q[ch_q][2]);
		rpt_sum = rpt_acc_q[ch_q] + 34'(meas_q);
		case (filt_sel_in[ch_q])
			FILT_MOVING: filt_val = mov_sum[33:2];
			FILT_REPEAT: filt_val = (rpt_n_q[ch_q] == 2'h3) ?
				rpt_sum[33:2] : rpt_hold_q[ch_q];
			default: filt_val = meas_q;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_in || chg[c]) begin
				hist_q[c][0] <= '0;
				hist_q[c][1] <= '0;
				hist_q[c][2] <= '0;
				rpt_acc_q[c] <= '0;
				rpt_n_q[c] <= '0;
				rpt_hold_q[c] <= '0;
			end else if (state_q == SQ_FILT && ch_q == CW'(c)) begin
				hist_q[c][0] <= meas_q;
				hist_q[c][1] <= hist_q[c][0];
				hist_q[c][2] <= hist_q[c][1];
				rpt_n_q[c] <= rpt_n_q[c] + 2'h1;
				if (rpt_n_q[c] == 2'h3) begin
					rpt_acc_q[c] <= '0;
					rpt_hold_q[c] <= filt_val;
				end else begin
					rpt_acc_q[c] <= rpt_sum;
				end
			end
		end
	end

	// limits are in the channel's own unit, the same as the measurement
	always_ff @(posedge clk_sys_in) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_in || chg[c]) begin
				err_q[c] <= 1'b0;
			end else if (state_q == SQ_FILT && ch_q == CW'(c)) begin
				err_q[c] <= (type_q[c] != CT_DIG)
					&& (filt_val < err_lo_in[c] || filt_val > err_hi_in[c]);
			end
		end
	end

	assign err_out = err_q;

	// shared restoring divider, one quotient bit per cycle
	assign trial = {rem_q, quo_q[DW-1]};
	assign div_done = busy_q && (dcnt_q == '0);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			busy_q <= 1'b0;
			dcnt_q <= '0;
			quo_q <= '0;
			rem_q <= '0;
		end else if (go_q) begin
			busy_q <= 1'b1;
			dcnt_q <= 6'(DW);
			quo_q <= num_q;
			rem_q <= '0;
		end else if (busy_q && dcnt_q != '0) begin
			dcnt_q <= dcnt_q - 6'h01;
			if (trial >= 33'(den_q)) begin
				rem_q <= 32'(trial - 33'(den_q));
				quo_q <= {quo_q[DW-2:0], 1'b1};
			end else begin
				rem_q <= trial[31:0];
				quo_q <= {quo_q[DW-2:0], 1'b0};
			end
		end else if (busy_q) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_q <= SQ_IDLE;
			ch_q <= '0;
			meas_q <= '0;
			meas_type_q <= CT_OFF;
			word_q <= '0;
			go_q <= 1'b0;
			num_q <= '0;
			den_q <= '0;
		end else begin
			go_q <= 1'b0;
			case (state_q)
				SQ_IDLE: begin
					if (tick_q) begin
						ch_q <= '0;
						state_q <= SQ_MEAS;
					end
				end
				SQ_MEAS: begin
					state_q <= SQ_FILT;
					meas_type_q <= cur_type;
					meas_q <= '0;
					case (cur_type)
						CT_VOLT, CT_CURR: begin
							meas_q <= sample_in[ch_q];
						end
						CT_DIG: begin
							meas_q <= {31'h0000_0000, lvl_q[ch_q]};
						end
						CT_PWM: begin
							if (per_q[ch_q] != '0) begin
								num_q <= DW'(hi_q[ch_q]) * DW'(`DUTY_FULL);
								den_q <= 32'(per_q[ch_q]);
								go_q <= 1'b1;
								state_q <= SQ_DIV1;
							end
						end
						CT_FREQ: begin
							if (!fresh_q[ch_q]) begin
								state_q <= last_ch ? SQ_IDLE : SQ_MEAS;
								ch_q <= ch_q + CW'(1);
							end else if (low_mode[ch_q]) begin
								if (per_q[ch_q] != '0) begin
									num_q <= DW'(`LOWF_SCALE);
									den_q <= 32'(per_q[ch_q]);
									go_q <= 1'b1;
									state_q <= SQ_DIV1;
								end
							end else begin
								num_q <= DW'(edges_lat_q[ch_q]) * DW'(`MS_PER_S);
								den_q <= (window_ms_in[ch_q] == '0) ?
									32'h0000_0001 : 32'(window_ms_in[ch_q]);
								go_q <= 1'b1;
								state_q <= SQ_DIV1;
							end
						end
						default: begin
							state_q <= last_ch ? SQ_IDLE : SQ_MEAS;
							ch_q <= ch_q + CW'(1);
						end
					endcase
				end
				SQ_DIV1: begin
					if (div_done) begin
						meas_q <= sat32(quo_q);
						state_q <= SQ_FILT;
					end
				end
				SQ_FILT: begin
					// below the offset clamps to zero rather than wrapping
					num_q <= (filt_val >= offset_in[ch_q]) ?
						DW'(filt_val - offset_in[ch_q]) : '0;
					den_q <= (resol_in[ch_q] == '0) ?
						32'h0000_0001 : resol_in[ch_q];
					go_q <= 1'b1;
					state_q <= SQ_DIV2;
				end
				SQ_DIV2: begin
					// a channel retyped while its sample was in flight drops it,
					// so a channel just disabled never emits an off-type word
					if (div_done && cur_type == meas_type_q) begin
						word_q <= {ch_q, cur_type, hund, sat32(quo_q)};
						state_q <= SQ_PUSH;
					end else if (div_done) begin
						state_q <= last_ch ? SQ_IDLE : SQ_MEAS;
						ch_q <= ch_q + CW'(1);
					end
				end
				SQ_PUSH: begin
					// a full fifo stalls the scan here
					if (wr_if.ready) begin
						state_q <= last_ch ? SQ_IDLE : SQ_MEAS;
						ch_q <= ch_q + CW'(1);
					end
				end
				default: begin
					state_q <= SQ_IDLE;
				end
			endcase
		end
	end

	assign wr_if.valid = state_q == SQ_PUSH;
	assign wr_if.data = word_q;

	word_fifo #(.W(MW), .DEPTH(DEPTH)) fifo_u (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.wr(wr_if),
		.rd_valid_out(msg_valid_out),
		.rd_data_out(msg_data_out),
		.rd_ready_in(msg_ready_in)
	);

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	property p_off_silent;
		wr_if.valid |-> word_q[`TYPE_LSB+2:`TYPE_LSB] != CT_OFF;
	endproperty
	a_off_silent: assert property (p_off_silent)
		else $error("disabled channel word pushed");

	property p_dig_state;
		state_q == SQ_MEAS && cur_type == CT_DIG
			|=> state_q == SQ_FILT && meas_q[31:1] == '0;
	endproperty
	a_dig_state: assert property (p_dig_state)
		else $error("digital sample not a single bit state");

	property p_dig_no_err;
		state_q == SQ_FILT && cur_type == CT_DIG && !chg[ch_q]
			|=> !err_q[$past(ch_q)];
	endproperty
	a_dig_no_err: assert property (p_dig_no_err)
		else $error("limit flag raised on digital channel");

	property p_timeout;
		per_cnt_q[0] == TO && !rise[0] && !chg[0] |=> per_q[0] == '0;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("edge timeout did not zero the period");

	property p_tick;
		tick_q |=> !tick_q [*8];
	endproperty
	a_tick: assert property (p_tick)
		else $error("scan ticks too close together");

	property p_reconf;
		chg[0] |=> per_cnt_q[0] == '0 && rpt_n_q[0] == '0 && !fresh_q[0];
	endproperty
	a_reconf: assert property (p_reconf)
		else $error("retype left channel state behind");

	property p_low_window;
		low_mode[0] && !chg[0] |=> win_q[0] == '0;
	endproperty
	a_low_window: assert property (p_low_window)
		else $error("window counted in edge interval mode");

	property p_duty_range;
		state_q == SQ_DIV1 && div_done && cur_type == CT_PWM
			|=> meas_q <= `DUTY_FULL && state_q == SQ_FILT;
	endproperty
	a_duty_range: assert property (p_duty_range)
		else $error("duty above one hundred percent");
endmodule
`default_nettype wire

/* File: logic/uic_cfg.svh */
// constants of the input channel scan: timing, scaling, field sizes
// assumes a 10 MHz system clock; included by design files only
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH

`define NUM_CH 8
`define FIFO_DEPTH 8
`define CLK_HZ 32'h0098_9680
`define US_PER_S 32'h000F_4240
`define SCAN_PERIOD_US 32'h0000_03E8
`define SCAN_CYC (`CLK_HZ / `US_PER_S * `SCAN_PERIOD_US)
`define EDGE_TIMEOUT_S 32'h0000_000A
`define EDGE_TIMEOUT_CYC (`EDGE_TIMEOUT_S * `CLK_HZ)
`define LOWF_LIMIT_HZ 16'h0032
`define HUNDREDTHS 32'h0000_0064
`define LOWF_SCALE (`CLK_HZ * `HUNDREDTHS)
`define DUTY_FULL 32'h0000_2710
`define MS_PER_S 32'h0000_03E8
`define PER_W 27
`define DIV_W 48
`define VAL_LSB 0
`define HUND_BIT 32
`define TYPE_LSB 33

`endif

/* File: logic/uic_pkg.sv */
// types shared by the input channel scan and its checks
// assumes nothing of its surroundings
package uic_pkg;

	typedef enum logic [2:0] {
		CT_OFF,
		CT_VOLT,
		CT_CURR,
		CT_DIG,
		CT_PWM,
		CT_FREQ
	} chan_type_t;

	typedef enum logic [1:0] {
		FILT_NONE,
		FILT_MOVING,
		FILT_REPEAT
	} filt_sel_t;

	typedef enum logic [2:0] {
		SQ_IDLE,
		SQ_MEAS,
		SQ_DIV1,
		SQ_FILT,
		SQ_DIV2,
		SQ_PUSH
	} seq_state_t;

endpackage

/* File: logic/word_fifo.sv */
// word fifo with a registered read port
// assumes DEPTH is a power of two; the reader may stall at will
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
	parameter int W = 39,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	word_stream_if.snk wr,
	output logic rd_valid_out,
	output logic [W-1:0] rd_data_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign wr.ready = cnt_q != (AW+1)'(DEPTH);
	assign push = wr.valid && wr.ready;
	// the output stage refills as soon as it is empty or being taken
	assign pop = (cnt_q != '0) && (!rd_valid_out || rd_ready_in);

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem[wp_q] <= wr.data;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + AW'(1);
			end
			if (pop) begin
				rp_q <= rp_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out <= '0;
		end else if (pop) begin
			rd_valid_out <= 1'b1;
			rd_data_out <= mem[rp_q];
		end else if (rd_ready_in) begin
			rd_valid_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: logic/word_stream_if.sv */
// valid/ready word stream between the scan sequencer and its fifo
// assumes both ends share one clock
`timescale 1ns/10ps
`default_nettype none
interface word_stream_if #(
	parameter int W = 39
);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: tb/field_signal_model.sv */
// stand-ins for the sensors and switches on the eight input pins
// assumes the bench sets converter values, wave periods and high times
`timescale 1ns/10ps
`default_nettype none
module field_signal_model #(
	parameter int NCH = 8
) (
	input wire logic clk_sys_in,
	input wire logic [31:0] analog_in [NCH],
	input wire logic [31:0] period_in [NCH],
	input wire logic [31:0] high_in [NCH],
	output logic [31:0] sample_out [NCH],
	output logic [NCH-1:0] level_out
);
	int cnt [NCH];
	initial begin
		level_out = '0;
		foreach (cnt[i]) begin
			sample_out[i] = '0;
			cnt[i] = 0;
		end
	end
	// falling edge keeps changes clear of the design's sampling edge
	always @(negedge clk_sys_in) begin
		for (int i = 0; i < NCH; i++) begin
			sample_out[i] <= analog_in[i];
			if (period_in[i] == 0) begin
				cnt[i] = 0;
				level_out[i] <= (high_in[i] != 0);
			end else begin
				cnt[i] = (cnt[i] + 1 >= period_in[i]) ? 0 : cnt[i] + 1;
				level_out[i] <= (cnt[i] < high_in[i]);
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/test_universal_input_channel_readout.sv */
// self-checking bench for the input channel scan
// assumes the field signal model stands on the input pins
`timescale 1ns/10ps
`default_nettype none
module test_universal_input_channel_readout;
	import uic_pkg::*;
	// shortened scan tick and edge timeout keep the run brief
	localparam int SCAN = 200;
	localparam int TMO = 12000;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	chan_type_t ct [8];
	filt_sel_t fs [8];
	logic [31:0] ana [8], per [8], hi [8], smp [8];
	logic [31:0] ofs [8], res [8], elo [8], ehi [8];
	logic [15:0] fmax [8], win [8];
	logic [7:0] lvl;
	logic [7:0] err;
	logic ready = 1'b0;
	logic vld;
	logic [38:0] dat;
	logic [38:0] w;
	logic [38:0] q [$];
	int err_total = 0;
	int checked = 0;

	always #50 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		if (vld === 1'b1 && ready === 1'b1) begin
			q.push_back(dat);
		end
	end

	field_signal_model field_signal_model_i (
		.clk_sys_in(clk_sys_in),
		.analog_in(ana),
		.period_in(per),
		.high_in(hi),
		.sample_out(smp),
		.level_out(lvl)
	);
	input_channel_scan #(
		.SCAN_CYCLES(SCAN),
		.TIMEOUT_CYCLES(TMO)
	) input_channel_scan_i (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.chan_type_in(ct),
		.filt_sel_in(fs),
		.sample_in(smp),
		.level_in(lvl),
		.offset_in(ofs),
		.resol_in(res),
		.err_lo_in(elo),
		.err_hi_in(ehi),
		.freq_max_in(fmax),
		.window_ms_in(win),
		.msg_ready_in(ready),
		.msg_valid_out(vld),
		.msg_data_out(dat),
		.err_out(err)
	);

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	function automatic logic [38:0] mk(int ch, chan_type_t t, logic h,
		logic [31:0] v);
		return {ch[2:0], t, h, v};
	endfunction

	task automatic ticks(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	task automatic all_off;
		@(negedge clk_sys_in);
		foreach (ct[i]) begin
			ct[i] = CT_OFF;
		end
	endtask

	// oldest queued word of one channel, bounded wait
	task automatic get_ch(input int ch, output logic [38:0] wd);
		int k;
		int j;
		bit got;
		got = 0;
		wd = '0;
		for (k = 0; k < 25000 && !got; k++) begin
			for (j = 0; j < q.size(); j++) begin
				if (q[j][38:36] == ch[2:0]) break;
			end
			if (j < q.size()) begin
				wd = q[j];
				q.delete(j);
				got = 1;
			end else begin
				@(posedge clk_sys_in);
			end
		end
		if (!got) begin
			err_total++;
			$display("[ERR] %0t no word from channel %0d", $time, ch);
		end
	endtask

	task automatic t_scan;
		@(negedge clk_sys_in);
		ready = 1'b0;
		for (int i = 0; i < 8; i++) begin
			ct[i] = CT_VOLT;
			ana[i] = 32'h0000_03E8 * (i + 1);
			ofs[i] = 32'h0000_0064 * i;
			res[i] = i + 1;
			ehi[i] = 32'h0000_0DAC;
		end
		ticks(4000);
		chk(vld, 1'b1);
		chk(err, 8'hF8);
		q.delete();
		ready = 1'b1;
		for (int i = 0; i < 8; i++) begin
			get_ch(i, w);
			chk(w, mk(i, CT_VOLT, 1'b0, (1000 * (i + 1) - 100 * i) / (i + 1)));
		end
		$display("t_scan done");
	endtask

	task automatic t_dig;
		int n;
		n = 0;
		all_off();
		ct[3] = CT_DIG;
		hi[3] = 32'h0000_0001;
		ofs[3] = '0;
		res[3] = 32'h0000_0001;
		// limits that would trip if checked
		elo[3] = 32'h0000_0005;
		ehi[3] = '0;
		ct[1] = CT_CURR;
		ana[1] = 32'h0000_2EE0;
		ofs[1] = 32'h0000_0FA0;
		res[1] = 32'h0000_03E8;
		ticks(3000);
		q.delete();
		get_ch(3, w);
		chk(w, mk(3, CT_DIG, 1'b0, 32'h0000_0001));
		get_ch(1, w);
		chk(w, mk(1, CT_CURR, 1'b0, 32'h0000_0008));
		chk(err[3], 1'b0);
		chk(err[1], 1'b1);
		@(negedge clk_sys_in);
		hi[3] = '0;
		ticks(3000);
		q.delete();
		get_ch(3, w);
		chk(w, mk(3, CT_DIG, 1'b0, 32'h0000_0000));
		ticks(3000);
		foreach (q[j]) begin
			n += (q[j][38:36] != 3'h3 && q[j][38:36] != 3'h1);
		end
		chk(n, 0);
		$display("t_dig done");
	endtask

	task automatic t_filt;
		all_off();
		ticks(2000);
		q.delete();
		ct[0] = CT_VOLT;
		fs[0] = FILT_MOVING;
		ana[0] = 32'h0000_0190;
		ofs[0] = '0;
		res[0] = 32'h0000_0001;
		for (int k = 0; k < 4; k++) begin
			get_ch(0, w);
			chk(w, mk(0, CT_VOLT, 1'b0, 100 * (k + 1)));
		end
		all_off();
		ticks(1000);
		q.delete();
		ct[0] = CT_VOLT;
		fs[0] = FILT_REPEAT;
		ana[0] = 32'h0000_0320;
		get_ch(0, w);
		chk(w, mk(0, CT_VOLT, 1'b0, 32'h0000_0000));
		repeat (7) get_ch(0, w);
		chk(w, mk(0, CT_VOLT, 1'b0, 32'h0000_0320));
		$display("t_filt done");
	endtask

	task automatic t_low;
		all_off();
		// edge mode at the limit; a one ms window would read differently
		ct[4] = CT_FREQ;
		fmax[4] = 16'h0032;
		win[4] = 16'h0001;
		per[4] = 32'h0000_0FA0;
		hi[4] = 32'h0000_07D0;
		ofs[4] = '0;
		res[4] = 32'h0000_0001;
		q.delete();
		repeat (2) get_ch(4, w);
		chk(w, mk(4, CT_FREQ, 1'b1, 32'h0003_D090));
		@(negedge clk_sys_in);
		per[4] = '0;
		hi[4] = '0;
		ticks(1000);
		q.delete();
		get_ch(4, w);
		chk(w, mk(4, CT_FREQ, 1'b1, 32'h0000_0000));
		$display("t_low done");
	endtask

	task automatic t_pwm;
		all_off();
		ct[6] = CT_PWM;
		per[6] = 32'h0000_03E8;
		hi[6] = 32'h0000_00FA;
		ofs[6] = '0;
		res[6] = 32'h0000_0001;
		ct[5] = CT_FREQ;
		fmax[5] = 16'h0033;
		// five ticks of window hold exactly one rising edge
		win[5] = 16'h0005;
		ofs[5] = '0;
		res[5] = 32'h0000_0001;
		per[5] = 32'h0000_03E8;
		hi[5] = 32'h0000_01F4;
		// the first wave period after a retype is one cycle short
		ticks(3000);
		q.delete();
		get_ch(6, w);
		chk(w, mk(6, CT_PWM, 1'b1, 32'h0000_09C4));
		get_ch(5, w);
		chk(w, mk(5, CT_FREQ, 1'b0, 32'h0000_00C8));
		$display("t_pwm done");
	endtask

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		foreach (ct[i]) begin
			ct[i] = CT_OFF;
			fs[i] = FILT_NONE;
			ana[i] = '0;
			per[i] = '0;
			hi[i] = '0;
			ofs[i] = '0;
			res[i] = 32'h0000_0001;
			elo[i] = '0;
			ehi[i] = 32'hFFFF_FFFF;
			fmax[i] = 16'h0000;
			win[i] = 16'h0001;
		end
		ticks(10);
		rst_in = 1'b0;
		t_scan();
		t_dig();
		t_filt();
		t_low();
		t_pwm();
		tally_and_finish();
	end

	// the tests need well under this many cycles
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		err_total++;
		$display("[ERR] %0t watchdog ran out", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
